/* omc_pkg.sv */
package omc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_PERIOD_NS       = 25;
    localparam int REG_RESET_DELAY_US  = 2000;
    localparam int REG_RESET_DELAY_CYC = REG_RESET_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int WAKE_RESET_US       = 2000;
    localparam int WAKE_RESET_CYC      = WAKE_RESET_US * 1000 / CLK_PERIOD_NS;
    localparam int WAKE_INT_LOW_US     = 56;
    localparam int WAKE_INT_LOW_CYC    = WAKE_INT_LOW_US * 1000 / CLK_PERIOD_NS;
    localparam int INT_REACT_NS        = 1000;
    localparam int INT_REACT_CYC       = INT_REACT_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame layout
    localparam int FRAME_ADDR_W = 6;
    localparam int FRAME_DATA_W = 24;

    localparam logic [5:0] ADDR_CONTROL_WORD_ONE        = 6'h01;
    localparam logic [5:0] ADDR_CONTROL_WORD_TWENTYTWO  = 6'h16;
    localparam logic [5:0] ADDR_CONFIGURATION_WORD      = 6'h3f;

    // Control word one: standby command field
    localparam int STBY_CMD_LSB = 1;
    localparam int STBY_CMD_W   = 3;
    localparam logic [2:0] STBY_CMD_RESET     = 3'h0;
    localparam logic [2:0] STBY_CMD_REG_ON    = 3'h3;
    localparam logic [2:0] STBY_CMD_DEEP      = 3'h5;

    // Control word twentytwo
    localparam int BIT_DEBUG_LEAVE_REQUEST     = 0;
    localparam int BIT_CURRENT_COMPARE_DISABLE = 1;
    localparam logic CURRENT_COMPARE_DISABLE_RESET = 1'b0;

    // Configuration word
    localparam int BIT_COMPARE_SETTING_UNLOCK  = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [FRAME_ADDR_W-1:0] addr;
        logic [FRAME_DATA_W-1:0] data;
    } omc_frame_t;

    typedef struct packed {
        logic main_regulator_en;
        logic aux_regulator_en;
        logic can_en;
        logic lin_en;
        logic power_outputs_en;
        logic contact_supply_output_en;
        logic watchdog_en;
    } omc_supply_t;

    typedef enum logic [3:0] {
        OMC_POWERUP,
        OMC_DEBUG_WAIT,
        OMC_ACTIVE,
        OMC_FLASH_CAN,
        OMC_FLASH_LIN,
        OMC_DEBUG,
        OMC_STBY_REG,
        OMC_STBY_DEEP,
        OMC_WAKE_RESET
    } omc_mode_t;

endpackage : omc_pkg

/* omc_sync.sv */
`timescale 1ns/1ps
module omc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // Two flops per bit
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (srst) begin
                meta_r[i] <= 1'b0;
                q[i]      <= 1'b0;
            end else if (ce) begin
                meta_r[i] <= d[i];
                q[i]      <= meta_r[i];
            end
        end
    end
endmodule : omc_sync

/* omc_pulse_timer.sv */
`timescale 1ns/1ps
module omc_pulse_timer #(
    parameter int DELAY_CYC = 1,
    parameter int WIDTH_CYC = 1
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic start,
    output logic      active
);
    localparam int CW = 16;
    localparam logic [CW-1:0] DELAY_LAST = CW'(DELAY_CYC - 1);
    localparam logic [CW-1:0] WIDTH_LAST = CW'(WIDTH_CYC - 1);

    logic [CW-1:0] cnt_r;
    logic          waiting_r;

    // Delay phase, then fixed active phase
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r     <= '0;
            waiting_r <= 1'b0;
            active    <= 1'b0;
        end else if (ce) begin
            if (start) begin
                cnt_r     <= '0;
                waiting_r <= 1'b1;
                active    <= 1'b0;
            end else if (waiting_r) begin
                cnt_r <= cnt_r + 1'b1;
                if (cnt_r == DELAY_LAST) begin
                    cnt_r     <= '0;
                    waiting_r <= 1'b0;
                    active    <= 1'b1;
                end
            end else if (active) begin
                cnt_r <= cnt_r + 1'b1;
                if (cnt_r == WIDTH_LAST) begin
                    cnt_r  <= '0;
                    active <= 1'b0;
                end
            end
        end
    end
endmodule : omc_pulse_timer

/* omc_mode_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE1: flash/debug: peripherals on, watchdog off, CAN on
// RULE2: regulator standby: main on, CAN/LIN/outputs off
// RULE3: deep standby: regulators, outputs, transmitters off
// RULE4: lin input high CAN flash, can input LIN
// RULE5: LIN flash sets fast rate enable
// RULE6: no standby entry from flash modes
// RULE7: flash exit: no reset pulse, long window
// RULE8: debug select at power-up gives debug mode
// RULE9: debug leave request exits debug, long window
// RULE10: pattern 011 regulator standby, 101 deep
// RULE11: standby command bits keep written value
// RULE12: standby entered on command frame end
// RULE13: compare enabled: long window, off on low current
// RULE14: compare disabled: watchdog off in standby
// RULE15: compare disable needs unlock in prior frame
// RULE16: host clears open-load bits before standby
// RULE17: regulator standby wake: interrupt low 56 us
// RULE18: deep standby wake gives reset pulse
// RULE19: wake reset pulse lasts 2 ms
// RULE20: chip-select fall wakes regulator standby only
// RULE21: default power-up: active mode, watchdog running
module omc_mode_ctrl
    import omc_pkg::*;
#(
    parameter int REG_RESET_DELAY = REG_RESET_DELAY_CYC,
    parameter int WAKE_RESET      = WAKE_RESET_CYC
) (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               ce,
    input  wire logic               lin_transmit_input,
    input  wire logic               can_transmit_input,
    input  wire logic               debug_select_input,
    input  wire logic               chip_select_n,
    input  wire omc_pkg::omc_frame_t spi_frame,
    input  wire logic               load_current_below_cmp,
    input  wire logic               wake_event,
    input  wire logic               contact_supply_cfg,
    input  wire logic               aux_regulator_cfg,
    output omc_pkg::omc_supply_t    supply,
    output omc_pkg::omc_mode_t      mode,
    output logic                    watchdog_long_window,
    output logic                    lin_fast_rate_enable,
    output logic                    reset_out_n,
    output logic                    wake_interrupt_out_n,
    output logic [2:0]              standby_command,
    output logic                    current_compare_disable,
    output logic                    compare_setting_unlock
);
    import omc_pkg::*;

    localparam int SYNC_W = 5 + FRAME_ADDR_W + FRAME_DATA_W;
    localparam logic [23:0] RESET_DELAY_LAST = 24'(REG_RESET_DELAY - 1);
    localparam logic [23:0] WAKE_RESET_LAST  = 24'(WAKE_RESET - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic              lin_tx_s;
    logic              can_tx_s;
    logic              debug_sel_s;
    logic              cs_n_s;
    logic              load_low_s;
    omc_frame_t        frame_s;
    logic              cs_n_d_r;
    logic              cs_rise;
    logic              cs_fall;

    assign sync_in = {lin_transmit_input, can_transmit_input, debug_select_input,
                      chip_select_n, load_current_below_cmp, spi_frame};

    omc_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk  (clk),
        .srst (srst),
        .ce   (ce),
        .d    (sync_in),
        .q    (sync_out)
    );

    assign {lin_tx_s, can_tx_s, debug_sel_s, cs_n_s, load_low_s, frame_s} = sync_out;

    always_ff @(posedge clk) begin
        if (srst) begin
            cs_n_d_r <= 1'b1;
        end else if (ce) begin
            cs_n_d_r <= cs_n_s;
        end
    end

    assign cs_rise = cs_n_s & ~cs_n_d_r;
    assign cs_fall = ~cs_n_s & cs_n_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // Frame decode
    logic       wr_cw1;
    logic       wr_cw22;
    logic       wr_cfg;
    logic [2:0] stby_field;
    logic       stby_reg_cmd;
    logic       stby_deep_cmd;
    logic       debug_leave_cmd;

    assign wr_cw1  = cs_rise && (frame_s.addr == ADDR_CONTROL_WORD_ONE);
    assign wr_cw22 = cs_rise && (frame_s.addr == ADDR_CONTROL_WORD_TWENTYTWO);
    assign wr_cfg  = cs_rise && (frame_s.addr == ADDR_CONFIGURATION_WORD);
    assign stby_field = frame_s.data[STBY_CMD_LSB +: STBY_CMD_W];
    assign stby_reg_cmd  = wr_cw1 && (stby_field == STBY_CMD_REG_ON);   // see RULE10
    assign stby_deep_cmd = wr_cw1 && (stby_field == STBY_CMD_DEEP);     // see RULE10
    assign debug_leave_cmd = wr_cw22 && frame_s.data[BIT_DEBUG_LEAVE_REQUEST];

    // Standby field holds what was written, also across wake
    always_ff @(posedge clk) begin
        if (srst) begin
            standby_command <= STBY_CMD_RESET;
        end else if (ce && wr_cw1) begin
            standby_command <= stby_field;                              // see RULE11
        end
    end

    // Unlock lives for exactly one following frame
    always_ff @(posedge clk) begin
        if (srst) begin
            compare_setting_unlock <= 1'b0;
        end else if (ce && cs_rise) begin
            compare_setting_unlock <= wr_cfg && frame_s.data[BIT_COMPARE_SETTING_UNLOCK]; // see RULE15
        end
    end

    // Setting to one needs the unlock; clearing is always taken
    always_ff @(posedge clk) begin
        if (srst) begin
            current_compare_disable <= CURRENT_COMPARE_DISABLE_RESET;
        end else if (ce && wr_cw22) begin
            if (!frame_s.data[BIT_CURRENT_COMPARE_DISABLE]) begin
                current_compare_disable <= 1'b0;
            end else if (compare_setting_unlock) begin
                current_compare_disable <= 1'b1;                        // see RULE15
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencer
    omc_mode_t   mode_r;
    omc_mode_t   mode_nxt;
    logic [23:0] cnt_r;
    logic        cnt_clr;
    logic        debug_seen_r;
    logic        wd_off_r;
    logic        long_win_nxt;
    logic        int_start;

    always_comb begin
        mode_nxt     = mode_r;
        cnt_clr      = 1'b0;
        long_win_nxt = 1'b0;
        int_start    = 1'b0;
        unique case (mode_r)
            OMC_POWERUP: begin
                if (cnt_r == RESET_DELAY_LAST) begin
                    cnt_clr = 1'b1;
                    if (debug_seen_r) begin
                        mode_nxt = OMC_DEBUG_WAIT;                      // see RULE8
                    end else begin
                        mode_nxt = OMC_ACTIVE;                          // see RULE21
                    end
                end
            end
            OMC_DEBUG_WAIT: begin
                if (!debug_sel_s) begin
                    mode_nxt = OMC_DEBUG;                               // see RULE8
                end
            end
            OMC_ACTIVE: begin
                if (lin_tx_s) begin
                    mode_nxt = OMC_FLASH_CAN;                           // see RULE4
                end else if (can_tx_s) begin
                    mode_nxt = OMC_FLASH_LIN;                           // see RULE4
                end else if (stby_reg_cmd) begin
                    mode_nxt     = OMC_STBY_REG;                        // see RULE12
                    long_win_nxt = !current_compare_disable;            // see RULE13
                end else if (stby_deep_cmd) begin
                    mode_nxt = OMC_STBY_DEEP;
                end
            end
            OMC_FLASH_CAN: begin
                // Standby commands are not looked at here; see RULE6
                if (!lin_tx_s) begin
                    mode_nxt     = OMC_ACTIVE;                          // see RULE7
                    long_win_nxt = 1'b1;
                end
            end
            OMC_FLASH_LIN: begin
                if (!can_tx_s) begin
                    mode_nxt     = OMC_ACTIVE;                          // see RULE7
                    long_win_nxt = 1'b1;
                end
            end
            OMC_DEBUG: begin
                if (debug_leave_cmd) begin
                    mode_nxt     = OMC_ACTIVE;                          // see RULE9
                    long_win_nxt = 1'b1;
                end
            end
            OMC_STBY_REG: begin
                if (wake_event || cs_fall) begin
                    mode_nxt  = OMC_ACTIVE;                             // see RULE20
                    int_start = 1'b1;                                   // see RULE17
                end
            end
            OMC_STBY_DEEP: begin
                // Serial access does not wake this mode
                if (wake_event) begin
                    mode_nxt = OMC_WAKE_RESET;                          // see RULE18
                    cnt_clr  = 1'b1;
                end
            end
            OMC_WAKE_RESET: begin
                if (cnt_r == WAKE_RESET_LAST) begin
                    mode_nxt = OMC_ACTIVE;                              // see RULE19
                    cnt_clr  = 1'b1;
                end
            end
            default: begin
                mode_nxt = OMC_POWERUP;
                cnt_clr  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_r <= OMC_POWERUP;
        end else if (ce) begin
            mode_r <= mode_nxt;
        end
    end

    // Shared counter for power-up delay and wake reset pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= '0;
        end else if (ce) begin
            if (cnt_clr) begin
                cnt_r <= '0;
            end else if (mode_r == OMC_POWERUP || mode_r == OMC_WAKE_RESET) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    // Debug strap seen during power-up
    always_ff @(posedge clk) begin
        if (srst) begin
            debug_seen_r <= 1'b0;
        end else if (ce && mode_r == OMC_POWERUP && debug_sel_s) begin
            debug_seen_r <= 1'b1;                                       // see RULE8
        end
    end

    // Watchdog off in regulator standby
    always_ff @(posedge clk) begin
        if (srst) begin
            wd_off_r <= 1'b0;
        end else if (ce) begin
            if (mode_r != OMC_STBY_REG) begin
                wd_off_r <= current_compare_disable;                    // see RULE14
            end else if (!current_compare_disable && load_low_s) begin
                wd_off_r <= 1'b1;                                       // see RULE13
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lin_fast_rate_enable <= 1'b0;
        end else if (ce && mode_r != OMC_FLASH_LIN && mode_nxt == OMC_FLASH_LIN) begin
            lin_fast_rate_enable <= 1'b1;                               // see RULE5
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake interrupt timing
    logic int_active;

    omc_pulse_timer #(
        .DELAY_CYC (INT_REACT_CYC),
        .WIDTH_CYC (WAKE_INT_LOW_CYC)
    ) u_int_timer (
        .clk    (clk),
        .srst   (srst),
        .ce     (ce),
        .start  (ce && int_start),
        .active (int_active)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output stage
    omc_supply_t supply_nxt;

    always_comb begin
        supply_nxt = '{default: 1'b1};
        unique case (mode_r)
            OMC_POWERUP, OMC_DEBUG_WAIT, OMC_WAKE_RESET: begin
                supply_nxt.watchdog_en = 1'b0;
            end
            OMC_ACTIVE: begin
                supply_nxt.watchdog_en = 1'b1;                          // see RULE21
            end
            OMC_FLASH_CAN, OMC_FLASH_LIN, OMC_DEBUG: begin
                supply_nxt.watchdog_en = 1'b0;                          // see RULE1
                supply_nxt.can_en      = 1'b1;                          // see RULE4
            end
            OMC_STBY_REG: begin
                supply_nxt.can_en                   = 1'b0;             // see RULE2
                supply_nxt.lin_en                   = 1'b0;
                supply_nxt.power_outputs_en         = 1'b0;
                supply_nxt.aux_regulator_en         = aux_regulator_cfg;
                supply_nxt.contact_supply_output_en = contact_supply_cfg;
                supply_nxt.watchdog_en              = !wd_off_r;
            end
            OMC_STBY_DEEP: begin
                supply_nxt.main_regulator_en        = 1'b0;             // see RULE3
                supply_nxt.aux_regulator_en         = 1'b0;
                supply_nxt.can_en                   = 1'b0;
                supply_nxt.lin_en                   = 1'b0;
                supply_nxt.power_outputs_en         = 1'b0;
                supply_nxt.contact_supply_output_en = contact_supply_cfg;
                supply_nxt.watchdog_en              = 1'b0;
            end
            default: begin
                supply_nxt.watchdog_en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            supply               <= '{default: 1'b0};
            mode                 <= OMC_POWERUP;
            watchdog_long_window <= 1'b0;
            reset_out_n          <= 1'b0;
            wake_interrupt_out_n <= 1'b1;
        end else if (ce) begin
            supply               <= supply_nxt;
            mode                 <= mode_r;
            watchdog_long_window <= long_win_nxt;
            reset_out_n          <= !(mode_r == OMC_POWERUP || mode_r == OMC_DEBUG_WAIT
                                      || mode_r == OMC_WAKE_RESET);     // see RULE18
            wake_interrupt_out_n <= !int_active;                        // see RULE17
        end
    end
endmodule : omc_mode_ctrl

/* omc_mode_ctrl_checker.sv */
`timescale 1ns/1ps
module omc_mode_ctrl_checker (
    input wire logic           clk,
    input wire logic           srst,
    input omc_pkg::omc_supply_t supply,
    input omc_pkg::omc_mode_t  mode,
    input wire logic           lin_fast_rate_enable,
    input wire logic           reset_out_n,
    input wire logic           wake_interrupt_out_n,
    input wire logic           current_compare_disable,
    input wire logic           compare_setting_unlock
);
    import omc_pkg::*;
    logic [11:0] int_low_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Length of the wake interrupt pulse
    always_ff @(posedge clk) begin
        if (srst || wake_interrupt_out_n) begin
            int_low_r <= '0;
        end else begin
            int_low_r <= int_low_r + 12'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_flash_supply:
        assert property (mode inside {OMC_FLASH_CAN, OMC_FLASH_LIN, OMC_DEBUG} |-> supply == 7'h7e)
        else $error("flash or debug supply wrong");
    a_fast_rate:
        assert property (mode == OMC_FLASH_LIN |=> lin_fast_rate_enable)
        else $error("fast rate not set in lin flash");
    a_reg_stby_supply:
        assert property (mode == OMC_STBY_REG |-> supply.main_regulator_en && !supply.can_en
            && !supply.lin_en && !supply.power_outputs_en)
        else $error("regulator standby supply wrong");
    a_deep_supply:
        assert property (mode == OMC_STBY_DEEP |-> supply[6:2] == 5'h00 && !supply.watchdog_en)
        else $error("deep standby supply wrong");
    a_ccd_wd_off:
        assert property (mode == OMC_STBY_REG && current_compare_disable |-> !supply.watchdog_en)
        else $error("watchdog on with compare disabled");
    a_ccd_unlock:
        assert property ($rose(current_compare_disable) |-> $past(compare_setting_unlock))
        else $error("compare disable set without unlock");
    a_int_width:
        assert property ($rose(wake_interrupt_out_n) |-> int_low_r == 12'(WAKE_INT_LOW_CYC))
        else $error("wake interrupt width wrong");
    a_flash_no_stby:
        assert property (mode inside {OMC_FLASH_CAN, OMC_FLASH_LIN}
            |=> !(mode inside {OMC_STBY_REG, OMC_STBY_DEEP}))
        else $error("standby entered from flash");
    a_reset_hold:
        assert property ($fell(reset_out_n) |-> !reset_out_n [*8])
        else $error("reset pulse too short");
endmodule : omc_mode_ctrl_checker

bind omc_mode_ctrl omc_mode_ctrl_checker i_chk (.clk, .srst, .supply, .mode,
    .lin_fast_rate_enable, .reset_out_n, .wake_interrupt_out_n, .current_compare_disable,
    .compare_setting_unlock);

/* omc_host_model.sv */
`timescale 1ns/1ps
module omc_host_model (
    input  wire logic           clk,
    input  wire logic [1:0]     lag,
    output logic                chip_select_n,
    output omc_pkg::omc_frame_t spi_frame
);
    import omc_pkg::*;
    initial begin
        chip_select_n = 1'b1;
        spi_frame     = '0;
    end
    // Open-load bits never set here
    task automatic xfer(input omc_frame_t f);
        @(posedge clk);
        spi_frame     <= f;
        chip_select_n <= 1'b0;
        repeat (4 + lag) @(posedge clk);
        chip_select_n <= 1'b1;
        repeat (4) @(posedge clk);
        spi_frame <= ~f;
        repeat (3) @(posedge clk);
    endtask : xfer
endmodule : omc_host_model

/* omc_mode_ctrl_tb.sv */
`timescale 1ns/1ps
module omc_mode_ctrl_tb;
    import omc_pkg::*;
    logic        clk, srst, lin_transmit_input, can_transmit_input, debug_select_input;
    logic        load_current_below_cmp, wake_event, contact_supply_cfg, aux_regulator_cfg;
    logic        chip_select_n, watchdog_long_window, lin_fast_rate_enable, reset_out_n;
    logic        wake_interrupt_out_n, current_compare_disable, compare_setting_unlock;
    logic [1:0]  host_lag;
    logic [2:0]  standby_command;
    omc_frame_t  spi_frame;
    omc_supply_t supply;
    omc_mode_t   mode, last_mode;
    omc_mode_t   exp_q[$];
    int          err_total, checks_done, cyc, wlw_cnt, c0, len;

    omc_mode_ctrl #(.REG_RESET_DELAY(20), .WAKE_RESET(20)) i_dut (
        .clk, .srst, .ce(1'b1), .lin_transmit_input, .can_transmit_input,
        .debug_select_input, .chip_select_n, .spi_frame, .load_current_below_cmp,
        .wake_event, .contact_supply_cfg, .aux_regulator_cfg, .supply, .mode,
        .watchdog_long_window, .lin_fast_rate_enable, .reset_out_n, .wake_interrupt_out_n,
        .standby_command, .current_compare_disable, .compare_setting_unlock);
    omc_host_model i_host (.clk, .lag(host_lag), .chip_select_n, .spi_frame);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic send(input logic [5:0] a, input logic [23:0] d);
        host_lag <= 2'($urandom);
        i_host.xfer({a, d});
        repeat (3) @(posedge clk);
    endtask : send
    task automatic wait_mode(input omc_mode_t m);
        int n = 0;
        while (mode !== m && n < 400) begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
    endtask : wait_mode
    task automatic low_len(input bit rst_pin, output int l);
        int n = 0;
        l = 0;
        while ((rst_pin ? reset_out_n : wake_interrupt_out_n) !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        while ((rst_pin ? reset_out_n : wake_interrupt_out_n) === 1'b0 && l < 3000) begin
            @(posedge clk);
            l++;
        end
    endtask : low_len
    task automatic pulse_wake();
        wake_event <= 1'b1;
        @(posedge clk);
        wake_event <= 1'b0;
    endtask : pulse_wake
    task automatic do_reset(input logic dbg);
        srst               <= 1'b1;
        debug_select_input <= dbg;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////////
    // Mode change monitor and pulse counter
    always @(posedge clk) begin
        if (!srst && mode !== last_mode && !(mode inside {OMC_POWERUP, OMC_DEBUG_WAIT})) begin
            if (exp_q.size() == 0) chk(8'(mode), 8'hff);
            else chk(8'(mode), 8'(exp_q.pop_front()));
        end
        last_mode <= mode;
        if (watchdog_long_window === 1'b1) wlw_cnt++;
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {srst, lin_transmit_input, can_transmit_input, debug_select_input} = 4'h0;
        {load_current_below_cmp, wake_event, host_lag} = 4'h0;
        void'($urandom(32'h0c76));
        contact_supply_cfg = 1'($urandom);
        aux_regulator_cfg  = 1'($urandom);
        do_reset(1'b0);
        exp_q.push_back(OMC_ACTIVE);
        wait_mode(OMC_ACTIVE);
        chk(8'(supply), 8'h7f);
        send(6'h01, 24'h000000);
        send(6'h01, 24'h00000c);
        chk(8'(standby_command), 8'h06);
        exp_q.push_back(OMC_STBY_REG);
        c0 = wlw_cnt;
        send(6'h01, 24'h000006);
        chk(8'(wlw_cnt - c0), 8'h01);
        chk(8'(supply), 8'({2'b01, aux_regulator_cfg, 3'h0, contact_supply_cfg, 1'b1}));
        load_current_below_cmp <= 1'b1;
        repeat (6) @(posedge clk);
        chk(8'(supply.watchdog_en), 8'h00);
        exp_q.push_back(OMC_ACTIVE);
        send(6'h3f, 24'h000000);
        low_len(1'b0, len);
        chk(8'(len == WAKE_INT_LOW_CYC), 8'h01);
        chk(8'(standby_command), 8'h03);
        send(6'h16, 24'h000002);
        chk(8'(current_compare_disable), 8'h00);
        send(6'h3f, 24'h000001);
        send(6'h16, 24'h000002);
        chk(8'({current_compare_disable, compare_setting_unlock}), 8'h02);
        load_current_below_cmp <= 1'b0;
        exp_q.push_back(OMC_STBY_REG);
        c0 = wlw_cnt;
        send(6'h01, 24'h000006);
        chk(8'({wlw_cnt != c0, supply.watchdog_en}), 8'h00);
        exp_q.push_back(OMC_ACTIVE);
        pulse_wake();
        low_len(1'b0, len);
        exp_q.push_back(OMC_STBY_DEEP);
        send(6'h01, 24'h00000a);
        chk(8'(supply), 8'({5'h00, contact_supply_cfg, 1'b0}));
        send(6'h3f, 24'h000000);
        exp_q.push_back(OMC_WAKE_RESET);
        exp_q.push_back(OMC_ACTIVE);
        pulse_wake();
        low_len(1'b1, len);
        chk(8'(len >= 20 && len <= 23), 8'h01);
        wait_mode(OMC_ACTIVE);
        for (int k = 0; k < 2; k++) begin
            exp_q.push_back(k == 0 ? OMC_FLASH_CAN : OMC_FLASH_LIN);
            if (k == 0) lin_transmit_input <= 1'b1;
            else can_transmit_input <= 1'b1;
            wait_mode(k == 0 ? OMC_FLASH_CAN : OMC_FLASH_LIN);
            chk(8'(supply), 8'h7e);
            chk(8'(lin_fast_rate_enable), 8'(k));
            send(6'h01, 24'h000006);
            exp_q.push_back(OMC_ACTIVE);
            c0 = wlw_cnt;
            {lin_transmit_input, can_transmit_input} <= 2'b00;
            wait_mode(OMC_ACTIVE);
            chk(8'({wlw_cnt - c0, reset_out_n}), 8'h03);
        end
        do_reset(1'b1);
        repeat (40) @(posedge clk);
        chk(8'(reset_out_n), 8'h00);
        exp_q.push_back(OMC_DEBUG);
        debug_select_input <= 1'b0;
        wait_mode(OMC_DEBUG);
        chk(8'({reset_out_n, supply}), 8'hfe);
        send(6'h01, 24'h000006);
        exp_q.push_back(OMC_ACTIVE);
        c0 = wlw_cnt;
        send(6'h16, 24'h000001);
        chk(8'(wlw_cnt - c0), 8'h01);
        chk(8'(exp_q.size()), 8'h00);
        finish_test();
    end
endmodule : omc_mode_ctrl_tb
